// ===== rtl/axis_converter.sv
// one sensing axis: self-test stimulus, range scaling and 16-bit result register
`timescale 1ns/10ps
`include "motion_cfg.svh"

module axis_converter #(
  parameter int RAW_W = `RAW_W
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     sample,
  input  wire logic                     st_en,
  input  wire logic [`FS_SEL_W-1:0]     fs_sel,
  input  wire logic signed [RAW_W-1:0]  raw,
  input  wire logic signed [RAW_W-1:0]  stim,
  output logic signed [`RESULT_W-1:0]   result
);

  localparam logic signed [RAW_W:0] RES_MAX = (RAW_W+1)'((1 <<< (`RESULT_W-1)) - 1);
  localparam logic signed [RAW_W:0] RES_MIN = -RES_MAX - (RAW_W+1)'(1);

  logic signed [RAW_W:0]         stim_sum;
  logic signed [RAW_W:0]         scaled;
  logic signed [`RESULT_W-1:0]   next_result;

  // stimulus, range shift and saturation, held between samples
  always_comb begin
    stim_sum = {raw[RAW_W-1], raw} + (st_en ? {stim[RAW_W-1], stim} : '0);
    scaled   = stim_sum >>> fs_sel;
    if (scaled > RES_MAX) begin
      next_result = RES_MAX[`RESULT_W-1:0];
    end else if (scaled < RES_MIN) begin
      next_result = RES_MIN[`RESULT_W-1:0];
    end else begin
      next_result = scaled[`RESULT_W-1:0];
    end
    if (!sample) begin
      next_result = result;
    end
  end

  // result register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      result <= `RESULT_RST;
    end else begin
      result <= next_result;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  hold_between_a: assert property (!sample |=> $stable(result))
    else $error("axis result changed without a sample");
  in_range_a: assert property (sample && !st_en && fs_sel == '0 && raw > RES_MIN
                              && raw < RES_MAX |=> result == $past(raw[`RESULT_W-1:0]))
    else $error("unity range result differs from raw value");

endmodule

// ===== rtl/motion_cfg.svh
// constants for the inertial sensor configuration core
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH

`define MCLK_HZ          10000000
`define BASE_RATE_HZ     8000
`define BASE_TICK_CYCLES (`MCLK_HZ / `BASE_RATE_HZ)
`define BASE_CNT_W       11
`define RATE_DIV_W       11
`define RATE_DIV_RST     11'h000
`define FS_SEL_W         2
`define RESULT_W         16
`define RESULT_RST       16'h0000
`define RAW_W            19
`define AXIS_CNT         6
`define GYRO_AXES        3
`define ST_STIMULUS      19'h01000
`define ADDR_UPPER       6'h34
`define ADDR_W           7
`define AXIS_SEL_W       3

`endif

// ===== rtl/motion_pkg.sv
// shared types for the inertial sensor configuration core
package motion_pkg;

  typedef struct packed {
    logic signed [15:0] z;
    logic signed [15:0] y;
    logic signed [15:0] x;
  } axis_result_t;

  typedef struct packed {
    axis_result_t accel;
    axis_result_t gyro;
  } sensor_results_t;

  typedef enum logic {
    CLK_RELAX_ONLY,
    CLK_AUTO_BEST
  } clk_src_sel_t;

  typedef enum logic {
    REF_RELAX_OSC,
    REF_GYRO_OSC
  } clk_ref_t;

endpackage

// ===== rtl/motion_sensor_core_config.sv
// configuration, conversion, self-test, clock source and pin logic of the inertial sensor
// Operation
// - software picks angular-rate range 250/500/1000/2000 dps; outputs scaled to match.
// - angular-rate sample rate programmable from 8000 down to 3.9 samples per second.
// - every axis has its own converter giving an independent 16-bit result.
// - software picks acceleration range 2/4/8/16 g; outputs scaled to match.
// - on both serial types the device is only a slave, never starts transfers.
// - lowest two-wire address bit comes from the sampled address select pin level.
// - four-wire mode shares pins; data-out pin doubles as address select in two-wire.
// - each interrupt pin can drive push-pull or open-drain.
// - self-test per axis of both sensors, actuating the axis to show a response.
// - internal clock from PLL fed by relaxation oscillator or automatic best source.
// - one internal clock drives all synchronous logic, conditioning, converters and registers.
// - two-wire address is fixed upper six bits plus address select as lowest bit.
`timescale 1ns/10ps
`include "motion_cfg.svh"

module motion_sensor_core_config #(
  parameter int                   BASE_TICKS = `BASE_TICK_CYCLES,
  parameter logic signed [`RAW_W-1:0] GYRO_STIM  = `ST_STIMULUS,
  parameter logic signed [`RAW_W-1:0] ACCEL_STIM = `ST_STIMULUS
) (
  input  wire logic                                   mclk,
  input  wire logic                                   rst_b,
  input  wire logic                                   spi_mode,
  input  wire logic                                   serial_clk,
  input  wire logic                                   chip_select_low,
  input  wire logic                                   address_select_pin_in,
  output logic                                        address_select_pin_out,
  output logic                                        address_select_pin_oe,
  input  wire logic                                   spi_sdo_data,
  input  wire logic                                   spi_sdo_en,
  input  wire logic [`FS_SEL_W-1:0]                   gyro_fs_sel,
  input  wire logic [`FS_SEL_W-1:0]                   accel_fs_sel,
  input  wire logic [`RATE_DIV_W-1:0]                 rate_div,
  input  wire logic [`AXIS_CNT-1:0]                   self_test_en,
  input  wire logic [`GYRO_AXES-1:0][`RAW_W-1:0]      gyro_raw,
  input  wire logic [`GYRO_AXES-1:0][`RAW_W-1:0]      accel_raw,
  input  wire motion_pkg::clk_src_sel_t               clk_src_sel,
  input  wire logic                                   gyro_osc_ok,
  output motion_pkg::clk_ref_t                        pll_ref,
  input  wire logic [1:0]                             int_level,
  input  wire logic [1:0]                             int_open_drain,
  output logic                                        interrupt_out_primary_out,
  output logic                                        interrupt_out_primary_oe,
  output logic                                        interrupt_out_secondary_out,
  output logic                                        interrupt_out_secondary_oe,
  input  wire logic                                   soft_reset,
  output logic                                        needs_soft_reset,
  output logic [`ADDR_W-1:0]                          slave_address,
  input  wire logic [`AXIS_SEL_W-1:0]                 read_axis,
  output logic [`RESULT_W-1:0]                        read_data,
  output motion_pkg::sensor_results_t                 results,
  output logic                                        gyro_sample
);

  localparam logic [`BASE_CNT_W-1:0] BASE_LAST = `BASE_CNT_W'(BASE_TICKS - 1);

  // ------------------------------------------------------------
  // sample timing
  // ------------------------------------------------------------
  logic [`BASE_CNT_W-1:0]  base_cnt;
  logic [`BASE_CNT_W-1:0]  next_base_cnt;
  logic [`RATE_DIV_W-1:0]  div_cnt;
  logic [`RATE_DIV_W-1:0]  next_div_cnt;
  logic                    base_tick;
  logic                    next_base_tick;
  logic                    next_gyro_sample;

  // base tick at 8 kHz, gyro strobe every rate_div+1 ticks down to 3.9 Hz
  always_comb begin
    next_base_cnt    = (base_cnt == BASE_LAST) ? '0 : base_cnt + `BASE_CNT_W'(1);
    next_base_tick   = (base_cnt == BASE_LAST);
    next_div_cnt     = div_cnt;
    next_gyro_sample = 1'b0;
    if (next_base_tick) begin
      if (div_cnt >= rate_div) begin
        next_div_cnt     = '0;
        next_gyro_sample = 1'b1;
      end else begin
        next_div_cnt = div_cnt + `RATE_DIV_W'(1);
      end
    end
    if (soft_reset) begin
      next_base_cnt    = '0;
      next_div_cnt     = `RATE_DIV_RST;
      next_base_tick   = 1'b0;
      next_gyro_sample = 1'b0;
    end
  end

  // all sequential logic runs on the single internal clock mclk
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      base_cnt    <= '0;
      div_cnt     <= `RATE_DIV_RST;
      base_tick   <= 1'b0;
      gyro_sample <= 1'b0;
    end else begin
      base_cnt    <= next_base_cnt;
      div_cnt     <= next_div_cnt;
      base_tick   <= next_base_tick;
      gyro_sample <= next_gyro_sample;
    end
  end

  // ------------------------------------------------------------
  // per-axis converters
  // ------------------------------------------------------------
  logic [`AXIS_CNT-1:0][`RAW_W-1:0]     raw_all;
  logic [`AXIS_CNT-1:0][`RESULT_W-1:0]  result_all;

  assign raw_all = {accel_raw, gyro_raw};

  // gyro axes use the divided rate, accel axes every base tick
  for (genvar i = 0; i < `AXIS_CNT; i++) begin : g_axis
    axis_converter #(
      .RAW_W (`RAW_W)
    ) u_axis (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .sample ((i < `GYRO_AXES) ? gyro_sample : base_tick),
      .st_en  (self_test_en[i]),
      .fs_sel ((i < `GYRO_AXES) ? gyro_fs_sel : accel_fs_sel),
      .raw    (raw_all[i]),
      .stim   ((i < `GYRO_AXES) ? GYRO_STIM : ACCEL_STIM),
      .result (result_all[i])
    );
  end

  assign results = motion_pkg::sensor_results_t'(result_all);

  // ------------------------------------------------------------
  // readout, power-up capture, clock source and pins
  // ------------------------------------------------------------
  function automatic logic [`RESULT_W-1:0] axis_pick(
    input logic [`AXIS_CNT-1:0][`RESULT_W-1:0] all,
    input logic [`AXIS_SEL_W-1:0]              sel
  );
    axis_pick = (sel < `AXIS_SEL_W'(`AXIS_CNT)) ? all[sel] : `RESULT_RST;
  endfunction

  logic                   boot_done;
  logic                   next_boot_done;
  logic                   next_needs_soft_reset;
  logic [`ADDR_W-1:0]     next_slave_address;
  logic [`RESULT_W-1:0]   next_read_data;
  motion_pkg::clk_ref_t   next_pll_ref;
  logic                   next_sdo_out;
  logic                   next_sdo_oe;
  logic [1:0]             next_int_out;
  logic [1:0]             next_int_oe;

  // next values for the pin side and configuration state
  always_comb begin
    next_boot_done        = 1'b1;
    next_slave_address    = slave_address;
    next_needs_soft_reset = needs_soft_reset;
    if (!boot_done) begin
      next_slave_address    = {`ADDR_UPPER, address_select_pin_in};
      next_needs_soft_reset = !serial_clk && !chip_select_low;
    end
    if (soft_reset) begin
      next_needs_soft_reset = 1'b0;
    end
    next_read_data = axis_pick(result_all, read_axis);
    next_pll_ref   = (clk_src_sel == motion_pkg::CLK_AUTO_BEST && gyro_osc_ok)
                     ? motion_pkg::REF_GYRO_OSC : motion_pkg::REF_RELAX_OSC;
    // the shared pin drives only when the host selects us in four-wire mode
    next_sdo_out = spi_sdo_data;
    next_sdo_oe  = spi_mode && !chip_select_low && spi_sdo_en;
    for (int k = 0; k < 2; k++) begin
      next_int_out[k] = int_open_drain[k] ? 1'b0 : int_level[k];
      next_int_oe[k]  = int_open_drain[k] ? int_level[k] : 1'b1;
    end
  end

  // output registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot_done                   <= 1'b0;
      needs_soft_reset            <= 1'b0;
      slave_address               <= {`ADDR_UPPER, 1'b0};
      read_data                   <= `RESULT_RST;
      pll_ref                     <= motion_pkg::REF_RELAX_OSC;
      address_select_pin_out      <= 1'b0;
      address_select_pin_oe       <= 1'b0;
      interrupt_out_primary_out   <= 1'b0;
      interrupt_out_primary_oe    <= 1'b0;
      interrupt_out_secondary_out <= 1'b0;
      interrupt_out_secondary_oe  <= 1'b0;
    end else begin
      boot_done                   <= next_boot_done;
      needs_soft_reset            <= next_needs_soft_reset;
      slave_address               <= next_slave_address;
      read_data                   <= next_read_data;
      pll_ref                     <= next_pll_ref;
      address_select_pin_out      <= next_sdo_out;
      address_select_pin_oe       <= next_sdo_oe;
      interrupt_out_primary_out   <= next_int_out[0];
      interrupt_out_primary_oe    <= next_int_oe[0];
      interrupt_out_secondary_out <= next_int_out[1];
      interrupt_out_secondary_oe  <= next_int_oe[1];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence tick_s;
    base_tick;
  endsequence

  sequence quiet_s;
    !base_tick [*8];
  endsequence

  upper_addr_a: assert property (boot_done |-> slave_address[`ADDR_W-1:1] == `ADDR_UPPER)
    else $error("slave address upper bits wrong");
  addr_capture_a: assert property (boot_done && !$past(boot_done)
                                   |-> slave_address[0] == $past(address_select_pin_in))
    else $error("address select level not captured");
  tick_spacing_a: assert property (tick_s |=> quiet_s)
    else $error("base ticks too close");
  gyro_on_tick_a: assert property (gyro_sample |-> $past(base_cnt) == BASE_LAST)
    else $error("gyro sample off the base tick");
  od_drive_a: assert property ($past(int_open_drain[0]) |-> !interrupt_out_primary_out)
    else $error("open-drain pin drove high");
  pp_drive_a: assert property (boot_done && !$past(int_open_drain[1]) |-> interrupt_out_secondary_oe
                               && interrupt_out_secondary_out == $past(int_level[1]))
    else $error("push-pull pin not driven");
  sdo_quiet_a: assert property (!$past(spi_mode) || $past(chip_select_low) |-> !address_select_pin_oe)
    else $error("data-out pin driven while not selected");
  soft_clear_a: assert property (soft_reset |=> !needs_soft_reset)
    else $error("soft reset did not clear power-up flag");
  relax_src_a: assert property (clk_src_sel == motion_pkg::CLK_RELAX_ONLY
                                |=> pll_ref == motion_pkg::REF_RELAX_OSC)
    else $error("relaxation-only source not honoured");
  read_back_a: assert property ($past(read_axis) == '0 |-> read_data == $past(result_all[0]))
    else $error("readout mismatch");

endmodule

// ===== tb/host_model.sv
// host-side model: boot soft reset, clock source choice, self-test judgement
`timescale 1ns/10ps

module host_model (
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                needs_soft_reset,
  input  wire logic                relax_req,
  output logic                     soft_reset,
  output motion_pkg::clk_src_sel_t clk_src_sel
);
  logic done;

  // one soft reset pulse, before anything else, when the boot pin check asks for it
  always @(negedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      soft_reset <= 1'h0;
      done       <= 1'h0;
    end else begin
      soft_reset <= needs_soft_reset && !done;
      done       <= done | needs_soft_reset;
    end
  end

  // automatic source unless the bench asks for the relaxation oscillator alone
  assign clk_src_sel = relax_req ? motion_pkg::CLK_RELAX_ONLY : motion_pkg::CLK_AUTO_BEST;

  // response is enabled minus disabled reading; pass only inside the limits
  function automatic logic st_pass(input logic signed [15:0] on_v, off_v, lo, hi);
    logic signed [16:0] resp;
    resp = on_v - off_v;
    return resp >= lo && resp <= hi;
  endfunction
endmodule

// ===== tb/testbench.sv
// self-checking bench for the inertial sensor configuration core
`timescale 1ns/10ps

module testbench;
  localparam int TK = 16; // shortened base tick
  typedef struct packed {logic [18:0] raw; logic [1:0] fs; logic st; logic [15:0] exp;} row_t;
  logic mclk, rst_b, spi_mode, serial_clk, chip_select_low, address_select_pin_in;
  logic address_select_pin_out, address_select_pin_oe, spi_sdo_data, spi_sdo_en;
  logic interrupt_out_primary_out, interrupt_out_primary_oe, interrupt_out_secondary_out;
  logic interrupt_out_secondary_oe, soft_reset, needs_soft_reset, gyro_sample, gyro_osc_ok, relax_req;
  logic [1:0]                  gyro_fs_sel, accel_fs_sel, int_level, int_open_drain;
  logic [10:0]                 rate_div;
  logic [5:0]                  self_test_en;
  logic [2:0][18:0]            gyro_raw, accel_raw;
  logic [2:0]                  read_axis;
  logic [15:0]                 read_data;
  logic [6:0]                  slave_address;
  motion_pkg::sensor_results_t results;
  motion_pkg::clk_src_sel_t    clk_src_sel;
  motion_pkg::clk_ref_t        pll_ref;
  int                          fail_count, checks, n;
  logic [10:0]                 divs [3] = '{11'h000, 11'h003, 11'h7FF};
  row_t rows [13] = '{'{19'h00100, 2'h0, 1'h0, 16'h0100}, '{19'h00100, 2'h1, 1'h0, 16'h0080},
    '{19'h00100, 2'h2, 1'h0, 16'h0040}, '{19'h00100, 2'h3, 1'h0, 16'h0020}, '{19'h7FFF0, 2'h0, 1'h0, 16'hFFF0},
    '{19'h7FFF0, 2'h2, 1'h0, 16'hFFFC}, '{19'h10000, 2'h0, 1'h0, 16'h7FFF}, '{19'h10000, 2'h1, 1'h0, 16'h7FFF},
    '{19'h10000, 2'h2, 1'h0, 16'h4000}, '{19'h40000, 2'h3, 1'h0, 16'h8000}, '{19'h70000, 2'h0, 1'h0, 16'h8000},
    '{19'h00100, 2'h0, 1'h1, 16'h1100}, '{19'h00100, 2'h1, 1'h1, 16'h0880}};

  motion_sensor_core_config #(.BASE_TICKS(TK)) motion_sensor_core_config_i (
    .mclk(mclk), .rst_b(rst_b), .spi_mode(spi_mode), .serial_clk(serial_clk),
    .chip_select_low(chip_select_low), .address_select_pin_in(address_select_pin_in),
    .address_select_pin_out(address_select_pin_out), .address_select_pin_oe(address_select_pin_oe),
    .spi_sdo_data(spi_sdo_data), .spi_sdo_en(spi_sdo_en), .gyro_fs_sel(gyro_fs_sel),
    .accel_fs_sel(accel_fs_sel), .rate_div(rate_div), .self_test_en(self_test_en), .gyro_raw(gyro_raw),
    .accel_raw(accel_raw), .clk_src_sel(clk_src_sel), .gyro_osc_ok(gyro_osc_ok), .pll_ref(pll_ref),
    .int_level(int_level), .int_open_drain(int_open_drain),
    .interrupt_out_primary_out(interrupt_out_primary_out), .interrupt_out_primary_oe(interrupt_out_primary_oe),
    .interrupt_out_secondary_out(interrupt_out_secondary_out),
    .interrupt_out_secondary_oe(interrupt_out_secondary_oe), .soft_reset(soft_reset),
    .needs_soft_reset(needs_soft_reset), .slave_address(slave_address), .read_axis(read_axis),
    .read_data(read_data), .results(results), .gyro_sample(gyro_sample));

  host_model host_model_i (.mclk(mclk), .rst_b(rst_b), .needs_soft_reset(needs_soft_reset),
    .relax_req(relax_req), .soft_reset(soft_reset), .clk_src_sel(clk_src_sel));

  //----------------------------------------
  // helpers
  //----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  // cycles until the next gyro strobe, bounded
  task automatic gap();
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (gyro_sample !== 1'h1 && n < 40000);
  endtask

  task automatic complete_run();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  //----------------------------------------
  // clock and watchdog
  //----------------------------------------
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    complete_run();
  end

  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    {rst_b, spi_mode, serial_clk, chip_select_low, spi_sdo_data, spi_sdo_en, gyro_osc_ok, relax_req} = 8'h00;
    {gyro_fs_sel, accel_fs_sel, int_level, int_open_drain, rate_div, self_test_en, read_axis} = 28'h0;
    {gyro_raw, accel_raw} = '0;
    address_select_pin_in = 1'h1;
    fail_count = 0;
    checks = 0;
    cyc(8);
    chk(16'(slave_address), 16'h0068);
    chk(16'(pll_ref), 16'(motion_pkg::REF_RELAX_OSC));
    rst_b = 1'h1;
    cyc(1);
    chk(16'(needs_soft_reset), 16'h0001);
    chk(16'(slave_address), 16'h0069);
    address_select_pin_in = 1'h0;
    cyc(2);
    chk(16'(needs_soft_reset), 16'h0000);
    chk(16'(slave_address), 16'h0069);
    // range scaling, saturation and self-test offset on every axis
    foreach (rows[i]) begin
      {gyro_fs_sel, accel_fs_sel, self_test_en} = {rows[i].fs, rows[i].fs, {6{rows[i].st}}};
      {gyro_raw, accel_raw} = {6{rows[i].raw}};
      cyc(2 * TK + 4);
      chk(results.gyro.x, rows[i].exp);
      chk(results.accel.z, rows[i].exp);
      for (int a = 0; a < 8; a++) begin
        read_axis = 3'(a);
        cyc(2);
        chk(read_data, (a < 6) ? rows[i].exp : 16'h0000);
      end
    end
    // self-test on one accel axis only, distinct raw values per axis
    {gyro_fs_sel, accel_fs_sel, self_test_en} = {4'h0, 6'h10};
    gyro_raw = {19'h00003, 19'h00002, 19'h00001};
    accel_raw = {19'h00006, 19'h00005, 19'h00004};
    cyc(2 * TK + 4);
    chk(results.gyro.x, 16'h0001);
    chk(results.gyro.y, 16'h0002);
    chk(results.gyro.z, 16'h0003);
    chk(results.accel.x, 16'h0004);
    chk(results.accel.y, 16'h1005);
    chk(results.accel.z, 16'h0006);
    chk(16'(host_model_i.st_pass(results.accel.y, 16'h0005, 16'h0800, 16'h2000)), 16'h0001);
    chk(16'(host_model_i.st_pass(results.accel.x, 16'h0004, 16'h0800, 16'h2000)), 16'h0000);
    // gyro strobe spacing at fastest, middle and slowest rate
    foreach (divs[j]) begin
      rate_div = divs[j];
      gap();
      gap();
      chk(16'(n), 16'(TK * (rate_div + 1)));
    end
    // interrupt pin drive types
    for (int v = 0; v < 16; v++) begin
      {int_open_drain, int_level} = 4'(v);
      cyc(2);
      chk(16'({interrupt_out_primary_out, interrupt_out_primary_oe, interrupt_out_secondary_out,
           interrupt_out_secondary_oe}), 16'({~int_open_drain[0] & int_level[0], ~int_open_drain[0] | int_level[0],
           ~int_open_drain[1] & int_level[1], ~int_open_drain[1] | int_level[1]}));
    end
    // shared data-out pin only driven while selected in four-wire mode
    for (int v = 0; v < 16; v++) begin
      {spi_mode, chip_select_low, spi_sdo_en, spi_sdo_data} = 4'(v);
      cyc(2);
      chk(16'({address_select_pin_out, address_select_pin_oe}),
          16'({spi_sdo_data, spi_mode & ~chip_select_low & spi_sdo_en}));
    end
    // clock reference choice
    for (int v = 0; v < 4; v++) begin
      {relax_req, gyro_osc_ok} = 2'(v);
      cyc(2);
      chk(16'(pll_ref), (!relax_req && gyro_osc_ok) ? 16'(motion_pkg::REF_GYRO_OSC) :
          16'(motion_pkg::REF_RELAX_OSC));
    end
    // second reset with serial clock high: no soft reset demanded
    {rst_b, serial_clk, chip_select_low, address_select_pin_in} = 4'h5;
    cyc(2);
    rst_b = 1'h1;
    cyc(2);
    chk(16'(needs_soft_reset), 16'h0000);
    chk(16'(slave_address), 16'h0069);
    complete_run();
  end
endmodule
